// ### hw/ctf_pair_mux.sv
`timescale 1ns/1ps
module ctf_pair_mux (
  // fifo words in, selected pixels out
  ctf_mux_if.mux bus
);
  import ctf_pkg::*;

  // odd muxes take the low byte (odd pixel), even muxes the high byte
  function automatic logic [7:0] pick(input logic [4:0][15:0] w, input logic [2:0] sel, input logic hi);
    logic [15:0] word;
    begin
      case (sel)
        3'h0: word = w[0];
        3'h1: word = w[1];
        3'h2: word = w[2];
        3'h3: word = w[3];
        3'h4: word = w[4];
        default: word = 16'h0000;
      endcase
      pick = hi ? word[15:8] : word[7:0];
    end
  endfunction

  always_comb begin
    for (int k = 0; k < 8; k++) begin
      bus.selected_pixel[k] = pick(bus.pair_word, bus.pair_select_bus[k/2], k[0]);
    end
  end
endmodule

// ### hw/ctf_tap_formatter.sv
// Summary of operation
// - ten-tap mode packs ten 8-bit pixels over 84 bits, starting at Tx0.
// - ten-tap: line/frame valid on Tx24/Tx25 first, line valid Tx27 others.
// - rate byte picks link clock 30, 42.5, 60 or 85 MHz.
// - window byte keeps binned bits 15:0 (0x00) or 17:2 (0x01).
// - five pair fifos, each with its own read strobe, pixels 1-2 to 9-10.
// - fifo word 16 bits: even pixel high byte, odd pixel low byte.
// - eight five-to-one muxes; odd ones odd pixels, even ones even pixels.
// - four 3-bit select buses, one per mux pair; zero picks pixels 1 and 2.
// - machine goes idle, first read, then loops until fifo line valid drops.
// - leaving empty starts a pre-read of all five fifos.
// - start also needs enough data, so no fifo under-runs mid-line.
// - one-tap: ten-cycle loop, pixels 1 to 10 from muxes one and two.
// - two-tap sends pairs 1-2 to 9-10; ten-tap all ten each clock.
// - four- and eight-tap rotate groups; pairs re-read a clock before use.
// - tap data and valids change only on the link output clock.
// - two-, four-, eight-tap run a five-cycle loop until line valid drops.
// - eight, four, two taps come straight from the first muxes.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "ctf_defs.svh"
module ctf_tap_formatter (
  // clock, reset, enable
  input  wire logic             CLK,
  input  wire logic             RST,
  input  wire logic             CE,
  // apb slave
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [11:0]      PADDR,
  input  wire logic [31:0]      PWDATA,
  output logic      [31:0]      PRDATA,
  output logic                  PREADY,
  output logic                  PSLVERR,
  // binned pixels from the data path
  input  wire logic             PIX_VALID,
  input  wire ctf_pkg::ctf_pix_t PIX_DATA,
  input  wire logic             PIX_LINE_VALID,
  input  wire logic             FRAME_VALID,
  output logic                  PIX_READY,
  // link transmitters
  output logic                  LINK_CLK,
  output ctf_pkg::ctf_tx_t      TX0,
  output ctf_pkg::ctf_tx_t      TX1,
  output ctf_pkg::ctf_tx_t      TX2
);
  import ctf_pkg::*;

  ctf_regs_t r_ff;
  ctf_regs_t nxt_r;

  ctf_mux_if mux_bus ();

  ctf_pair_mux u_mux (
    .bus (mux_bus)
  );

  // register decode shared by read, write and error
  function automatic logic [2:0] reg_index(input logic [11:0] addr);
    begin
      case (addr)
        `CTF_REG_RATE:   reg_index = 3'h1;
        `CTF_REG_WINDOW: reg_index = 3'h2;
        `CTF_REG_TAPS:   reg_index = 3'h3;
        `CTF_REG_STATUS: reg_index = 3'h4;
        default:         reg_index = 3'h0;
      endcase
    end
  endfunction

  // phase step of the link clock accumulator, rate * 2^bits / system clock
  function automatic logic [`CTF_ACC_BITS-1:0] phase_step(input logic [7:0] rate);
    logic [63:0] khz;
    begin
      case (rate)
        `CTF_RATE_42: khz = 64'(`CTF_F42_KHZ);
        `CTF_RATE_60: khz = 64'(`CTF_F60_KHZ);
        `CTF_RATE_85: khz = 64'(`CTF_F85_KHZ);
        default:      khz = 64'(`CTF_F30_KHZ);
      endcase
      phase_step = `CTF_ACC_BITS'((khz << `CTF_ACC_BITS) / 64'(`CTF_CLK_KHZ));
    end
  endfunction

  // 18-bit binned value to the 8-bit pixel carried by the link
  function automatic logic [7:0] window_pick(input logic [17:0] p, input logic [7:0] sel);
    logic [15:0] kept;
    begin
      kept = (sel == `CTF_WIN_HIGH) ? p[17:2] : p[15:0];
      window_pick = kept[15:8];
    end
  endfunction

  function automatic logic [2:0] mod5add(input logic [2:0] a, input logic [2:0] b);
    logic [3:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      mod5add = (s >= 4'h5) ? 3'(s - 4'h5) : s[2:0];
    end
  endfunction

  // mux pairs consumed per output clock
  function automatic logic [2:0] pairs_per_clk(input logic [2:0] mode);
    begin
      case (mode)
        `CTF_TAPS_2: pairs_per_clk = 3'h1;
        `CTF_TAPS_4: pairs_per_clk = 3'h2;
        `CTF_TAPS_8: pairs_per_clk = 3'h4;
        `CTF_TAPS_10: pairs_per_clk = 3'h5;
        default:     pairs_per_clk = 3'h1;
      endcase
    end
  endfunction

  // fifos touched by this output clock, starting at the base select
  function automatic logic [4:0] used_mask(input logic [2:0] mode, input logic [2:0] base);
    logic [2:0] n;
    logic [2:0] f;
    begin
      used_mask = 5'h00;
      n = pairs_per_clk(mode);
      for (int k = 0; k < 5; k++) begin
        f = mod5add(base, 3'(k));
        if (3'(k) < n) begin
          used_mask[f] = 1'b1;
        end
      end
    end
  endfunction

  // place taps and valids on the three transmitters
  function automatic logic [2:0][27:0] pack_tx(input logic [2:0] mode, input logic [9:0][7:0] px,
                                               input logic lval, input logic fval);
    logic [83:0] flat;
    int          src;
    begin
      flat = '0;
      src  = 0;
      if (mode == `CTF_TAPS_10) begin
        for (int p = 0; p < 84; p++) begin
          if (p == `CTF_TX_LVAL) begin
            flat[p] = lval;
          end else if (p == `CTF_TX_FVAL) begin
            flat[p] = fval;
          end else if (p == `CTF_TX_BITS + `CTF_TX_LVAL_HI || p == 2 * `CTF_TX_BITS + `CTF_TX_LVAL_HI) begin
            flat[p] = lval;
          end else begin
            flat[p] = px[src / 8][src % 8];
            src     = src + 1;
          end
        end
      end else begin
        // one byte per tap, three taps a transmitter, valids on every one
        for (int n = 0; n < 8; n++) begin
          flat[(n / 3) * `CTF_TX_BITS + (n % 3) * 8 +: 8] = px[n];
        end
        for (int t = 0; t < 3; t++) begin
          flat[t * `CTF_TX_BITS + `CTF_TX_LVAL] = lval;
          flat[t * `CTF_TX_BITS + `CTF_TX_FVAL] = fval;
        end
      end
      pack_tx = flat;
    end
  endfunction

  // select buses follow the base; idle base of zero restores 0,1,2,3
  always_comb begin
    for (int f = 0; f < 5; f++) begin
      mux_bus.pair_word[f] = r_ff.head[f][15:0];
    end
    for (int k = 0; k < 4; k++) begin
      mux_bus.pair_select_bus[k] = mod5add(r_ff.base, 3'(k));
    end
  end

  always_comb begin
    logic [4:0]        empty_f;
    logic [4:0]        used;
    logic [4:0]        rd;
    logic              any_full;
    logic              wr_go;
    logic              tick;
    logic              fifo_line_valid;
    logic              starved;
    logic              line_end;
    logic [`CTF_ACC_BITS:0] acc_sum;
    logic [9:0][7:0]   px;
    logic [`CTF_AW:0]  level;
    logic [2:0]        ridx;
    logic [31:0]       status;
    empty_f         = 5'h00;
    used            = 5'h00;
    rd              = 5'h00;
    any_full        = 1'b0;
    wr_go           = 1'b0;
    tick            = 1'b0;
    fifo_line_valid = 1'b0;
    starved         = 1'b0;
    line_end        = 1'b0;
    acc_sum         = '0;
    px              = '0;
    level           = '0;
    ridx            = 3'h0;
    status          = 32'h0000_0000;
    nxt_r           = r_ff;

    for (int f = 0; f < 5; f++) begin
      empty_f[f] = (r_ff.rptr[f] == r_ff.wptr);
      if ((r_ff.wptr - r_ff.rptr[f]) == 5'(`CTF_DEPTH)) begin
        any_full = 1'b1;
      end
    end
    level = r_ff.wptr - r_ff.rptr[0];

    // no square wave above half the system clock fits, so the link clock is a strobe per period
    acc_sum         = {1'b0, r_ff.acc} + {1'b0, phase_step(r_ff.rate)};
    nxt_r.acc       = acc_sum[`CTF_ACC_BITS-1:0];
    tick            = acc_sum[`CTF_ACC_BITS];
    nxt_r.link_clk  = tick;

    // apb: read data latched in setup, write at the access edge
    ridx = reg_index(PADDR);
    status[`CTF_ST_STATE +: 2] = r_ff.state;
    status[`CTF_ST_BASE +: 3]  = r_ff.base;
    status[`CTF_ST_PHASE +: 4] = r_ff.phase;
    status[`CTF_ST_LEVEL +: 5] = level;
    status[`CTF_ST_LINES +: 5] = r_ff.lines;
    status[`CTF_ST_EMPTY +: 5] = empty_f;
    if (PSEL && !PENABLE) begin
      case (ridx)
        3'h1:    nxt_r.prdata = {24'h000000, r_ff.rate};
        3'h2:    nxt_r.prdata = {24'h000000, r_ff.window};
        3'h3:    nxt_r.prdata = {29'h00000000, r_ff.taps};
        3'h4:    nxt_r.prdata = status;
        default: nxt_r.prdata = 32'h0000_0000;
      endcase
    end
    if (PSEL && PENABLE && PWRITE) begin
      case (ridx)
        3'h1:    nxt_r.rate   = PWDATA[7:0];
        3'h2:    nxt_r.window = PWDATA[7:0];
        3'h3:    nxt_r.taps   = PWDATA[2:0];
        default: nxt_r.taps   = r_ff.taps;
      endcase
    end

    // output machine
    fifo_line_valid = r_ff.head[r_ff.base][16];
    used            = used_mask(r_ff.taps_run, r_ff.base);
    case (r_ff.state)
      CTF_IDLE: begin
        nxt_r.base  = 3'h0;
        nxt_r.sub   = 1'b0;
        nxt_r.phase = 4'h0;
        // a full line queued or enough words to stay ahead of the reads
        if (tick && empty_f == 5'h00 && (level >= `CTF_START_LEVEL || r_ff.lines != '0)) begin
          rd             = 5'h1f;
          nxt_r.taps_run = (r_ff.taps > `CTF_TAPS_10) ? `CTF_TAPS_10 : r_ff.taps;
          nxt_r.state    = CTF_FIRST_READ;
        end
      end
      CTF_FIRST_READ: begin
        if (tick) begin
          nxt_r.state = CTF_RUN;
        end
      end
      CTF_RUN: begin
        if (tick) begin
          if (!fifo_line_valid) begin
            line_end    = 1'b1;
            nxt_r.state = CTF_IDLE;
            nxt_r.base  = 3'h0;
            nxt_r.tx    = pack_tx(r_ff.taps_run, px, 1'b0, FRAME_VALID);
          end else begin
            starved = |(used & empty_f);
            if (r_ff.taps_run == `CTF_TAPS_10) begin
              for (int f = 0; f < 5; f++) begin
                px[2*f]   = r_ff.head[f][7:0];
                px[2*f+1] = r_ff.head[f][15:8];
              end
            end else if (r_ff.taps_run == `CTF_TAPS_1) begin
              px[0] = r_ff.sub ? mux_bus.selected_pixel[1] : mux_bus.selected_pixel[0];
            end else begin
              for (int k = 0; k < 8; k++) begin
                px[k] = mux_bus.selected_pixel[k];
              end
            end
            if (starved) begin
              // hold the group; line valid low so the grabber skips this clock
              nxt_r.tx = pack_tx(r_ff.taps_run, px, 1'b0, FRAME_VALID);
            end else begin
              nxt_r.tx = pack_tx(r_ff.taps_run, px, 1'b1, FRAME_VALID);
              if (r_ff.taps_run == `CTF_TAPS_1) begin
                nxt_r.sub   = ~r_ff.sub;
                nxt_r.phase = (r_ff.phase == 4'h9) ? 4'h0 : r_ff.phase + 4'h1;
                if (r_ff.sub) begin
                  rd         = used;
                  nxt_r.base = mod5add(r_ff.base, 3'h1);
                end
              end else begin
                // each used pair refills now, at least one clock before its next use
                rd          = used;
                nxt_r.base  = mod5add(r_ff.base, pairs_per_clk(r_ff.taps_run));
                nxt_r.phase = (r_ff.phase == 4'h4) ? 4'h0 : r_ff.phase + 4'h1;
              end
            end
          end
        end
      end
      default: begin
        nxt_r.state = CTF_IDLE;
      end
    endcase

    // per-fifo read strobes load the head registers
    for (int f = 0; f < 5; f++) begin
      if (rd[f]) begin
        nxt_r.head[f] = r_ff.mem[f][r_ff.rptr[f][`CTF_AW-1:0]];
        nxt_r.rptr[f] = r_ff.rptr[f] + 5'h01;
      end
    end

    // write side: one word into each of the five fifos
    wr_go = PIX_VALID && !any_full;
    if (wr_go) begin
      for (int f = 0; f < 5; f++) begin
        nxt_r.mem[f][r_ff.wptr[`CTF_AW-1:0]] = {PIX_LINE_VALID, window_pick(PIX_DATA[2*f+1], r_ff.window),
                                                window_pick(PIX_DATA[2*f], r_ff.window)};
      end
      nxt_r.wptr = r_ff.wptr + 5'h01;
    end
    // count of line-end markers still queued
    if (wr_go && !PIX_LINE_VALID && !line_end) begin
      nxt_r.lines = r_ff.lines + 5'h01;
    end else if (line_end && !(wr_go && !PIX_LINE_VALID) && r_ff.lines != '0) begin
      nxt_r.lines = r_ff.lines - 5'h01;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      r_ff        <= '0;
      r_ff.rate   <= `CTF_RATE_RST;
      r_ff.window <= `CTF_WINDOW_RST;
      r_ff.taps   <= `CTF_TAPS_RST;
    end else if (CE) begin
      r_ff <= nxt_r;
    end
  end

  // zero-wait slave; error only for an unmapped access phase
  assign PREADY    = 1'b1;
  assign PSLVERR   = PSEL && PENABLE && (reg_index(PADDR) == 3'h0);
  assign PRDATA    = r_ff.prdata;
  assign PIX_READY = ~(|{(r_ff.wptr - r_ff.rptr[0]) == 5'(`CTF_DEPTH),
                         (r_ff.wptr - r_ff.rptr[1]) == 5'(`CTF_DEPTH),
                         (r_ff.wptr - r_ff.rptr[2]) == 5'(`CTF_DEPTH),
                         (r_ff.wptr - r_ff.rptr[3]) == 5'(`CTF_DEPTH),
                         (r_ff.wptr - r_ff.rptr[4]) == 5'(`CTF_DEPTH)});
  assign LINK_CLK  = r_ff.link_clk;
  assign TX0       = r_ff.tx[0];
  assign TX1       = r_ff.tx[1];
  assign TX2       = r_ff.tx[2];
endmodule

// ### pkg/ctf_defs.svh
`ifndef CTF_DEFS_SVH
`define CTF_DEFS_SVH

// register byte offsets on the apb slave
`define CTF_REG_RATE      12'h000
`define CTF_REG_WINDOW    12'h004
`define CTF_REG_TAPS      12'h008
`define CTF_REG_STATUS    12'h00c

// reset values
`define CTF_RATE_RST      8'h00
`define CTF_WINDOW_RST    8'h00
`define CTF_TAPS_RST      3'h4

// tap mode register codes
`define CTF_TAPS_1        3'h0
`define CTF_TAPS_2        3'h1
`define CTF_TAPS_4        3'h2
`define CTF_TAPS_8        3'h3
`define CTF_TAPS_10       3'h4

// link clock rate select codes and rates
`define CTF_RATE_30       8'h00
`define CTF_RATE_42       8'h01
`define CTF_RATE_60       8'h02
`define CTF_RATE_85       8'h03
`define CTF_CLK_KHZ       100000
`define CTF_F30_KHZ       30000
`define CTF_F42_KHZ       42500
`define CTF_F60_KHZ       60000
`define CTF_F85_KHZ       85000
`define CTF_ACC_BITS      16

// binned bit window select codes
`define CTF_WIN_LOW       8'h00
`define CTF_WIN_HIGH      8'h01

// pair fifos
`define CTF_NFIFO         5
`define CTF_DEPTH         16
`define CTF_AW            4
`define CTF_START_LEVEL   5'h04

// transmitter bit positions
`define CTF_TX_BITS       28
`define CTF_TX_LVAL       24
`define CTF_TX_FVAL       25
`define CTF_TX_LVAL_HI    27

// status register field positions
`define CTF_ST_STATE      0
`define CTF_ST_BASE       4
`define CTF_ST_PHASE      8
`define CTF_ST_LEVEL      12
`define CTF_ST_LINES      20
`define CTF_ST_EMPTY      24

`endif

// ### pkg/ctf_mux_if.sv
`timescale 1ns/1ps
interface ctf_mux_if;
  logic [4:0][15:0] pair_word;
  logic [3:0][2:0]  pair_select_bus;
  logic [7:0][7:0]  selected_pixel;

  modport stage (output pair_word, output pair_select_bus, input selected_pixel);
  modport mux   (input pair_word, input pair_select_bus, output selected_pixel);
endinterface

// ### pkg/ctf_pkg.sv
package ctf_pkg;
`include "ctf_defs.svh"

  typedef enum logic [1:0] {CTF_IDLE, CTF_FIRST_READ, CTF_RUN} ctf_state_t;

  typedef logic [9:0][17:0]  ctf_pix_t;
  typedef logic [27:0]       ctf_tx_t;

  typedef struct packed {
    ctf_state_t                                   state;
    logic [7:0]                                   rate;
    logic [7:0]                                   window;
    logic [2:0]                                   taps;
    logic [2:0]                                   taps_run;
    logic [`CTF_ACC_BITS-1:0]                     acc;
    logic                                         link_clk;
    logic [`CTF_NFIFO-1:0][`CTF_AW:0]             rptr;
    logic [`CTF_AW:0]                             wptr;
    logic [`CTF_AW:0]                             lines;
    logic [`CTF_NFIFO-1:0][16:0]                  head;
    logic [2:0]                                   base;
    logic                                         sub;
    logic [3:0]                                   phase;
    logic [2:0][27:0]                             tx;
    logic [31:0]                                  prdata;
    logic [`CTF_NFIFO-1:0][`CTF_DEPTH-1:0][16:0]  mem;
  } ctf_regs_t;

endpackage

// ### testbench/ctf_grabber.sv
`timescale 1ns/1ps
module ctf_grabber (
  // sampling
  input wire logic             clk,
  input wire logic             link_clk,
  input wire logic [2:0]       mode,
  // transmitters
  input wire ctf_pkg::ctf_tx_t tx0,
  input wire ctf_pkg::ctf_tx_t tx1,
  input wire ctf_pkg::ctf_tx_t tx2
);
  import ctf_pkg::*;
  logic [7:0]       got[$];
  logic [79:0]      ten;
  logic [2:0][27:0] txs;
  int               n;
  assign ten = {tx2[26:0], tx1[26:0], tx0[27:26], tx0[23:0]};
  assign txs = {tx2, tx1, tx0};
  // link clock arrives as a one-cycle strobe per link period, aligned with fresh tap bits
  always @(posedge clk) begin
    n = (mode == 3'h0) ? 1 : (mode == 3'h1) ? 2 : (mode == 3'h2) ? 4 : (mode == 3'h3) ? 8 : 10;
    if (link_clk && tx0[24]) begin
      for (int k = 0; k < n; k++)
        got.push_back(n == 10 ? ten[8 * k +: 8] : txs[k / 3][(k % 3) * 8 +: 8]);
    end
  end
endmodule

// ### testbench/ctf_tap_formatter_bench.sv
`timescale 1ns/1ps
`include "ctf_defs.svh"
module ctf_tap_formatter_bench;
  import ctf_pkg::*;
  logic        CLK = 1'b0;
  logic        RST = 1'b1;
  logic        CE = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h0;
  logic [31:0] PWDATA = 32'h0;
  logic        PIX_VALID = 1'b0;
  ctf_pix_t    PIX_DATA = '0;
  logic        PIX_LINE_VALID = 1'b0;
  logic        FRAME_VALID = 1'b0;
  logic [2:0]  mode = `CTF_TAPS_RST;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        PIX_READY;
  logic        LINK_CLK;
  ctf_tx_t     TX0;
  ctf_tx_t     TX1;
  ctf_tx_t     TX2;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic [31:0] rd;
  logic        er;

  ctf_tap_formatter dut (.CLK, .RST, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .PIX_VALID, .PIX_DATA, .PIX_LINE_VALID, .FRAME_VALID, .PIX_READY, .LINK_CLK, .TX0, .TX1, .TX2);
  ctf_grabber g (.clk(CLK), .link_clk(LINK_CLK), .mode(mode), .tx0(TX0), .tx1(TX1), .tx2(TX2));

  initial begin
    forever #5 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic summarize();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // leading edge keeps psel low a cycle between calls
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  function automatic logic [17:0] pv(input int i);
    return 18'(i * 32'h4d5) + 18'h15a3;
  endfunction

  // four pixel words then the line-end marker, valid held throughout
  task automatic send_line(input int base);
    @(posedge CLK);
    PIX_VALID <= 1'b1;
    for (int w = 0; w < 5; w++) begin
      PIX_LINE_VALID <= (w < 4);
      for (int k = 0; k < 10; k++)
        PIX_DATA[k] <= pv(base + 10 * w + k);
      do @(posedge CLK); while (PIX_READY !== 1'b1);
    end
    PIX_VALID <= 1'b0;
  endtask

  // 40 pixels close every group rotation of every tap count
  task automatic run_line(input logic [2:0] taps, input logic [7:0] win, input int base);
    int          t;
    logic [17:0] p;
    apb(1'b1, `CTF_REG_TAPS, {29'h0, taps});
    apb(1'b1, `CTF_REG_WINDOW, {24'h0, win});
    mode = taps;
    g.got.delete();
    send_line(base);
    t = 0;
    while (g.got.size() < 40 && t < 3000) begin
      @(posedge CLK);
      t++;
    end
    check(g.got.size(), 32'h28, "pixel count per line");
    for (int i = 0; i < 40; i++) begin
      p = pv(base + i);
      check(g.got[i], win == `CTF_WIN_HIGH ? p[17:10] : p[15:8], "pixel order");
    end
  endtask

  task automatic t_regs();
    apb(1'b0, `CTF_REG_RATE, 32'h0);
    check(rd, {24'h0, `CTF_RATE_RST}, "rate reset");
    apb(1'b0, `CTF_REG_WINDOW, 32'h0);
    check(rd, {24'h0, `CTF_WINDOW_RST}, "window reset");
    apb(1'b0, `CTF_REG_TAPS, 32'h0);
    check(rd, {29'h0, `CTF_TAPS_RST}, "taps reset");
    apb(1'b1, `CTF_REG_WINDOW, 32'h1);
    apb(1'b0, `CTF_REG_WINDOW, 32'h0);
    check(rd, 32'h1, "window readback");
    apb(1'b1, 12'h010, 32'hff);
    check(er, 1'b1, "unmapped write error");
    apb(1'b0, 12'h010, 32'h0);
    check(rd, 32'h0, "unmapped read data");
    check(er, 1'b1, "unmapped read error");
    apb(1'b0, `CTF_REG_STATUS, 32'h0);
    check(er, 1'b0, "status is mapped");
  endtask

  task automatic t_rate();
    int   khz [4] = '{`CTF_F30_KHZ, `CTF_F42_KHZ, `CTF_F60_KHZ, `CTF_F85_KHZ};
    int   n;
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, `CTF_REG_RATE, r);
      n = 0;
      repeat (1000) begin
        @(posedge CLK);
        n += LINK_CLK;
      end
      // one strobe per link period; one of slack where the count window opens
      check(n >= khz[r] / 100 - 1 && n <= khz[r] / 100 + 1, 1'b1, "link clock rate");
    end
  endtask

  task automatic t_modes();
    for (int m = 0; m < 5; m++)
      run_line(3'(m), `CTF_WIN_LOW, 50 * m);
  endtask

  task automatic t_window();
    run_line(`CTF_TAPS_10, `CTF_WIN_HIGH, 300);
    run_line(`CTF_TAPS_2, `CTF_WIN_HIGH, 340);
  endtask

  initial begin
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    FRAME_VALID <= 1'b1;
    t_regs();
    t_rate();
    t_modes();
    t_window();
    summarize();
  end
endmodule

// ### testbench/ctf_tap_formatter_chk.sv
`timescale 1ns/1ps
`include "ctf_defs.svh"
module ctf_tap_formatter_chk (
  // clock and reset
  input wire logic             CLK,
  input wire logic             RST,
  input wire logic             CE,
  // apb
  input wire logic             PSEL,
  input wire logic             PENABLE,
  input wire logic             PWRITE,
  input wire logic [11:0]      PADDR,
  input wire logic [31:0]      PWDATA,
  input wire logic [31:0]      PRDATA,
  input wire logic             PREADY,
  input wire logic             PSLVERR,
  // pixels and link
  input wire logic             FRAME_VALID,
  input wire logic             PIX_READY,
  input wire logic             LINK_CLK,
  input wire ctf_pkg::ctf_tx_t TX0,
  input wire ctf_pkg::ctf_tx_t TX1,
  input wire ctf_pkg::ctf_tx_t TX2
);
  import ctf_pkg::*;
  logic [2:0] taps_ff;
  wire        in_access = PSEL && PENABLE;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // mode shadowed from apb writes, the register itself is out of sight
  always_ff @(posedge CLK) begin
    if (RST)
      taps_ff <= `CTF_TAPS_RST;
    else if (CE && in_access && PWRITE && PADDR == `CTF_REG_TAPS)
      taps_ff <= PWDATA[2:0];
  end
  a_ready_const: assert property (PREADY)
    else $error("pready low");
  a_err_map: assert property (in_access && PADDR[1:0] == 2'h0 |-> PSLVERR == (PADDR > `CTF_REG_STATUS))
    else $error("pslverr does not follow the address map");
  a_err_idle: assert property (!in_access |-> !PSLVERR)
    else $error("pslverr outside access phase");
  a_rdata_hold: assert property ($changed(PRDATA) |-> $past(PSEL && !PENABLE))
    else $error("prdata moved outside a setup cycle");
  a_tx_tick: assert property ($changed({TX0, TX1, TX2}) |-> LINK_CLK)
    else $error("transmitter bits moved without a link clock strobe");
  a_ten_lval: assert property (taps_ff == `CTF_TAPS_10 |-> TX1[27] == TX0[24] && TX2[27] == TX0[24])
    else $error("ten-tap line valid copies differ");
  a_fval_copy: assert property ($changed(TX0[`CTF_TX_FVAL]) |-> TX0[`CTF_TX_FVAL] == $past(FRAME_VALID))
    else $error("frame valid bit not taken from input");
  a_link_rate: assert property (!LINK_CLK |-> ##[1:4] LINK_CLK)
    else $error("link clock slower than lowest rate");
  a_reset_vals: assert property (disable iff (1'b0) RST |=> !LINK_CLK && PIX_READY && TX0 == 28'h0 && PRDATA == 32'h0)
    else $error("outputs not cleared by reset");
  c_line: cover property ($rose(TX0[`CTF_TX_LVAL]));
  c_one_tap: cover property (taps_ff == `CTF_TAPS_1 && $fell(TX0[`CTF_TX_LVAL]));
  c_err: cover property (PSLVERR);
endmodule
bind ctf_tap_formatter ctf_tap_formatter_chk u_chk (.CLK, .RST, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PWDATA, .PRDATA, .PREADY, .PSLVERR, .FRAME_VALID, .PIX_READY, .LINK_CLK, .TX0, .TX1, .TX2);
